// >>> rtl/cbe_branch_eval.sv
// Notes on behaviour
// - integer branches test condition codes against field
// - zero and signed integer condition encodings
// - unsigned, sign and overflow integer encodings
// - integer always: delayed transfer, annul suppresses slot
// - integer never: no transfer, annul suppresses slot
// - taken conditional branch always executes slot
// - untaken conditional branch annuls slot if set
// - target is pc plus four times offset
// - float branches test condition code zero
// - float encodings without equal
// - float encodings including equal
// - float always transfers, annul suppresses slot
// - float never: no transfer, annul suppresses slot
// - fpu off or absent raises unavailable trap
// - branch after compare sees new code
`timescale 1ns/1ps
`default_nettype none
module cbe_branch_eval
	import cbe_pkg::*;
#(
	parameter int PC_W = 64
)(
	input  wire logic            core_clk,
	input  wire logic            reset,
	input  wire logic            branch_valid,
	output logic                 branch_ready,
	input  wire logic [31:0]     branch_word,
	input  wire logic [PC_W-1:0] branch_pc,
	input  wire logic [3:0]      int_cond_codes,
	input  wire logic            fcmp_valid,
	input  wire logic [1:0]      fcmp_result,
	input  wire logic            fpu_enable_flag,
	input  wire logic            float_enable_state,
	input  wire logic            fpu_present,
	input  wire logic            slot_done,
	output logic                 result_valid,
	output logic                 result_taken,
	output logic                 result_annul,
	output logic [PC_W-1:0]      result_target,
	output logic                 not_branch,
	output logic                 fp_unavailable_trap,
	output logic                 redirect_valid,
	output logic [PC_W-1:0]      redirect_pc,
	output logic [1:0]           fp_cond_code_zero
);

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	logic                annul_bit;
	logic [3:0]          cond;
	logic [2:0]          form;
	logic [CBE_OFFSET_W-1:0] word_offset_field;
	logic                is_int;
	logic                is_float;
	logic                uncond;
	logic                op_ok;
	logic                cond_always;
	logic                cond_never;

	assign annul_bit = branch_word[CBE_ANNUL_BIT];
	assign cond      = branch_word[CBE_COND_HI:CBE_COND_LO];
	assign form      = branch_word[CBE_FORM_HI:CBE_FORM_LO];
	assign word_offset_field = branch_word[CBE_OFFSET_HI:0];

	assign op_ok = (branch_word[CBE_OP_HI:CBE_OP_LO] == CBE_OP_BRANCH);

	// only the two branch forms are ours
	always_comb begin
		is_int   = 1'b0;
		is_float = 1'b0;
		case (form)
			CBE_FORM_INT: begin
				is_int = op_ok;
			end
			CBE_FORM_FLOAT: begin
				is_float = op_ok;
			end
			default: begin
				is_int   = 1'b0;
				is_float = 1'b0;
			end
		endcase
	end

	assign cond_always = (cond == CBE_COND_ALWAYS);
	assign cond_never  = (cond == CBE_COND_NEVER);
	assign uncond      = cond_always || cond_never;

	// ------------------------------------------------------------
	// floating-point condition code
	// ------------------------------------------------------------
	logic [1:0] next_fp_cond_code_zero;
	logic [1:0] fcc_seen;

	// bypass a compare finishing this cycle
	always_comb begin
		next_fp_cond_code_zero = fp_cond_code_zero;
		if (fcmp_valid) begin
			next_fp_cond_code_zero = fcmp_result;
		end
	end

	// no bubble needed between compare and branch
	assign fcc_seen = next_fp_cond_code_zero;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fp_cond_code_zero <= CBE_FCC_RESET;
		end else begin
			fp_cond_code_zero <= next_fp_cond_code_zero;
		end
	end

	// ------------------------------------------------------------
	// condition evaluation
	// ------------------------------------------------------------
	logic int_true;
	logic fp_true;
	logic fpu_usable;
	logic cond_true;
	logic taken;
	logic annul;
	logic [PC_W-1:0] offset_bytes;
	logic [PC_W-1:0] target;
	logic [PC_W-CBE_OFFSET_W-CBE_WORD_SHIFT-1:0] sign_fill;

	cbe_int_cond u_int_cond (
		.cond           (cond),
		.int_cond_codes (int_cond_codes),
		.result         (int_true)
	);

	cbe_fp_cond u_fp_cond (
		.cond              (cond),
		.fp_cond_code_zero (fcc_seen),
		.result            (fp_true)
	);

	// float branch needs an enabled fpu
	assign fpu_usable = fpu_enable_flag && float_enable_state
			&& fpu_present;

	assign cond_true = is_float ? fp_true : int_true;

	assign taken = cond_true;

	// annul rule differs between the two kinds of branch
	always_comb begin
		if (uncond) begin
			annul = annul_bit;
		end else if (taken) begin
			annul = 1'b0;
		end else begin
			annul = annul_bit;
		end
	end

	// sign extended word offset, times four
	assign sign_fill    = {(PC_W - CBE_OFFSET_W - CBE_WORD_SHIFT)
			{word_offset_field[CBE_OFFSET_W-1]}};
	// the sum wraps at the top of the pc, no overflow flag
	assign offset_bytes = {sign_fill, word_offset_field,
			{CBE_WORD_SHIFT{1'b0}}};
	assign target = branch_pc + offset_bytes;

	// ------------------------------------------------------------
	// delay slot sequencer
	// ------------------------------------------------------------
	cbe_state_t      state;
	cbe_state_t      next_state;
	logic            accept;
	logic            trap_now;
	logic            next_result_valid;
	logic            next_result_taken;
	logic            next_result_annul;
	logic [PC_W-1:0] next_result_target;
	logic            next_not_branch;
	logic            next_fp_unavailable_trap;
	logic            next_redirect_valid;
	logic [PC_W-1:0] next_redirect_pc;

	// stalls while a slot is outstanding, so the target waits
	assign branch_ready = (state == CBE_IDLE);
	assign accept       = branch_valid && branch_ready;
	assign trap_now     = accept && is_float && !fpu_usable;

	always_comb begin
		next_state               = state;
		next_result_valid        = 1'b0;
		next_not_branch          = 1'b0;
		next_fp_unavailable_trap = 1'b0;
		next_redirect_valid      = 1'b0;
		case (state)
			CBE_IDLE: begin
				if (accept) begin
					if (!is_int && !is_float) begin
						next_not_branch = 1'b1;
					end else if (trap_now) begin
						next_fp_unavailable_trap = 1'b1;
					end else begin
						next_result_valid = 1'b1;
						next_state = CBE_SLOT;
					end
				end
			end
			CBE_SLOT: begin
				if (slot_done) begin
					next_redirect_valid = result_taken;
					next_state          = CBE_IDLE;
				end
			end
			default: begin
				next_state = CBE_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state               <= CBE_IDLE;
			result_valid        <= 1'b0;
			not_branch          <= 1'b0;
			fp_unavailable_trap <= 1'b0;
			redirect_valid      <= 1'b0;
		end else begin
			state               <= next_state;
			result_valid        <= next_result_valid;
			not_branch          <= next_not_branch;
			fp_unavailable_trap <= next_fp_unavailable_trap;
			redirect_valid      <= next_redirect_valid;
		end
	end

	// ------------------------------------------------------------
	// decision hold
	// ------------------------------------------------------------
	logic load_decision;
	logic slot_end;

	// traps and foreign words leave the last decision in place
	assign load_decision = next_result_valid;
	assign slot_end      = (state == CBE_SLOT) && slot_done;

	always_comb begin
		next_result_taken  = result_taken;
		next_result_annul  = result_annul;
		next_result_target = result_target;
		if (load_decision) begin
			next_result_taken  = taken;
			next_result_annul  = annul;
			next_result_target = target;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			result_taken  <= 1'b0;
			result_annul  <= 1'b0;
			result_target <= '0;
		end else begin
			result_taken  <= next_result_taken;
			result_annul  <= next_result_annul;
			result_target <= next_result_target;
		end
	end

	// ------------------------------------------------------------
	// fetch redirect address
	// ------------------------------------------------------------
	always_comb begin
		next_redirect_pc = redirect_pc;
		if (slot_end) begin
			next_redirect_pc = result_target;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			redirect_pc <= '0;
		end else begin
			redirect_pc <= next_redirect_pc;
		end
	end

endmodule
`default_nettype wire

// >>> pkg/cbe_pkg.sv
`default_nettype none
package cbe_pkg;

	// ------------------------------------------------------------
	// branch word layout
	// ------------------------------------------------------------
	localparam int CBE_OP_HI       = 31;
	localparam int CBE_OP_LO       = 30;
	localparam int CBE_ANNUL_BIT   = 29;
	localparam int CBE_COND_HI     = 28;
	localparam int CBE_COND_LO     = 25;
	localparam int CBE_FORM_HI     = 24;
	localparam int CBE_FORM_LO     = 22;
	localparam int CBE_OFFSET_HI   = 21;
	localparam int CBE_OFFSET_W    = 22;
	localparam int CBE_WORD_SHIFT  = 2;

	localparam logic [1:0] CBE_OP_BRANCH  = 2'h0;
	localparam logic [2:0] CBE_FORM_INT   = 3'h2;
	localparam logic [2:0] CBE_FORM_FLOAT = 3'h6;

	// ------------------------------------------------------------
	// condition field values
	// ------------------------------------------------------------
	localparam logic [3:0] CBE_COND_NEVER  = 4'h0;
	localparam logic [3:0] CBE_COND_ALWAYS = 4'h8;
	localparam int         CBE_COND_NEG    = 3;

	// integer condition code bit positions
	localparam int CBE_ICC_C = 0;
	localparam int CBE_ICC_V = 1;
	localparam int CBE_ICC_Z = 2;
	localparam int CBE_ICC_N = 3;

	// floating-point condition code values
	localparam logic [1:0] CBE_FCC_EQ = 2'h0;
	localparam logic [1:0] CBE_FCC_LT = 2'h1;
	localparam logic [1:0] CBE_FCC_GT = 2'h2;
	localparam logic [1:0] CBE_FCC_UN = 2'h3;

	localparam logic [1:0] CBE_FCC_RESET = 2'h0;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CBE_IDLE = 2'h1,
		CBE_SLOT = 2'h2
	} cbe_state_t;

endpackage
`default_nettype wire

// >>> rtl/cbe_int_cond.sv
`timescale 1ns/1ps
`default_nettype none
module cbe_int_cond
	import cbe_pkg::*;
(
	input  wire logic [3:0] cond,
	input  wire logic [3:0] int_cond_codes,
	output logic            result
);

	logic n;
	logic z;
	logic v;
	logic c;
	logic base;

	assign n = int_cond_codes[CBE_ICC_N];
	assign z = int_cond_codes[CBE_ICC_Z];
	assign v = int_cond_codes[CBE_ICC_V];
	assign c = int_cond_codes[CBE_ICC_C];

	// ------------------------------------------------------------
	// upper half of the codes is the negation of the lower half
	// ------------------------------------------------------------
	always_comb begin
		case (cond[2:0])
			3'h0: base = 1'b0;
			3'h1: base = z;
			3'h2: base = z | (n ^ v);
			3'h3: base = n ^ v;
			3'h4: base = c | z;
			3'h5: base = c;
			3'h6: base = n;
			3'h7: base = v;
			default: base = 1'b0;
		endcase
	end

	assign result = base ^ cond[CBE_COND_NEG];

endmodule
`default_nettype wire

// >>> rtl/cbe_fp_cond.sv
`timescale 1ns/1ps
`default_nettype none
module cbe_fp_cond
	import cbe_pkg::*;
(
	input  wire logic [3:0] cond,
	input  wire logic [1:0] fp_cond_code_zero,
	output logic            result
);

	// accepted relations, bit order {un, gt, lt, eq}
	logic [3:0] accept;
	logic [3:0] relation;

	always_comb begin
		case (cond)
			4'h0: accept = 4'h0;
			4'h1: accept = 4'hE;
			4'h2: accept = 4'h6;
			4'h3: accept = 4'hA;
			4'h4: accept = 4'h2;
			4'h5: accept = 4'hC;
			4'h6: accept = 4'h4;
			4'h7: accept = 4'h8;
			4'h8: accept = 4'hF;
			4'h9: accept = 4'h1;
			4'hA: accept = 4'h9;
			4'hB: accept = 4'h5;
			4'hC: accept = 4'hD;
			4'hD: accept = 4'h3;
			4'hE: accept = 4'hB;
			4'hF: accept = 4'h7;
			default: accept = 4'h0;
		endcase
	end

	always_comb begin
		relation = 4'h0;
		case (fp_cond_code_zero)
			CBE_FCC_EQ: relation = 4'h1;
			CBE_FCC_LT: relation = 4'h2;
			CBE_FCC_GT: relation = 4'h4;
			CBE_FCC_UN: relation = 4'h8;
			default:    relation = 4'h0;
		endcase
	end

	assign result = |(accept & relation);

endmodule
`default_nettype wire

// >>> tb/cbe_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cbe_monitor #(
	parameter int PC_W = 64
)(
	input wire logic            core_clk,
	input wire logic            reset,
	input wire logic            branch_valid,
	input wire logic            branch_ready,
	input wire logic [31:0]     branch_word,
	input wire logic [PC_W-1:0] branch_pc,
	input wire logic            fcmp_valid,
	input wire logic [1:0]      fcmp_result,
	input wire logic            fpu_enable_flag,
	input wire logic            float_enable_state,
	input wire logic            fpu_present,
	input wire logic            slot_done,
	input wire logic            result_valid,
	input wire logic            result_taken,
	input wire logic            result_annul,
	input wire logic [PC_W-1:0] result_target,
	input wire logic            not_branch,
	input wire logic            fp_unavailable_trap,
	input wire logic            redirect_valid,
	input wire logic [PC_W-1:0] redirect_pc,
	input wire logic [1:0]      fp_cond_code_zero
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	wire logic [3:0] cond = branch_word[28:25];
	wire logic annul_bit = branch_word[29];
	wire logic is_int = branch_word[31:30] == 2'h0 && branch_word[24:22] == 3'h2;
	wire logic is_fp = branch_word[31:30] == 2'h0 && branch_word[24:22] == 3'h6;
	wire logic fp_on = fpu_enable_flag && float_enable_state && fpu_present;
	wire logic [PC_W-1:0] tgt = branch_pc
		+ {{(PC_W-24){branch_word[21]}}, branch_word[21:0], 2'h0};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_take;
		branch_valid && branch_ready;
	endsequence
	sequence s_good;
		s_take ##0 (is_int || (is_fp && fp_on));
	endsequence
	sequence s_slot;
		slot_done && !branch_ready && !result_valid;
	endsequence

	a_ready_low: assert property (
		result_valid |-> !branch_ready)
		else $error("ready high during slot");
	a_one_answer: assert property (
		$onehot0({result_valid, not_branch, fp_unavailable_trap}))
		else $error("more than one answer");
	a_good_result: assert property (
		s_good |=> result_valid)
		else $error("branch gave no result");
	a_target_calc: assert property (
		s_good |=> result_target == $past(tgt))
		else $error("target wrong");
	a_uncond_annul: assert property (
		s_good ##0 cond[2:0] == 3'h0 |=> result_taken == ($past(cond) == 4'h8)
		&& result_annul == $past(annul_bit))
		else $error("always or never branch wrong");
	a_cond_annul: assert property (
		s_good ##0 cond[2:0] != 3'h0
		|=> result_annul == (!result_taken && $past(annul_bit)))
		else $error("conditional annul wrong");
	a_trap_raise: assert property (
		s_take ##0 is_fp && !fp_on |=> fp_unavailable_trap && !result_valid)
		else $error("disabled float branch not trapped");
	a_fcc_load: assert property (
		fcmp_valid |=> fp_cond_code_zero == $past(fcmp_result))
		else $error("compare code not held");
	a_redirect_slot: assert property (
		s_slot ##0 result_taken |=> redirect_valid && branch_ready
		&& redirect_pc == result_target)
		else $error("redirect missing after slot");
endmodule

bind cbe_branch_eval cbe_monitor #(.PC_W(PC_W)) u_mon (.core_clk, .reset,
	.branch_valid, .branch_ready, .branch_word, .branch_pc, .fcmp_valid,
	.fcmp_result, .fpu_enable_flag, .float_enable_state, .fpu_present,
	.slot_done, .result_valid, .result_taken, .result_annul, .result_target,
	.not_branch, .fp_unavailable_trap, .redirect_valid, .redirect_pc,
	.fp_cond_code_zero);
`default_nettype wire

// >>> tb/cbe_slot_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbe_slot_model (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       result_valid,
	input  wire logic [2:0] slot_wait,
	output logic            slot_done
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	always_comb begin
		next_cnt = cnt;
		if (result_valid)
			next_cnt = slot_wait;
		else if (cnt != 3'h0)
			next_cnt = cnt - 3'h1;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			cnt <= 3'h0;
		else
			cnt <= next_cnt;
	end
	assign slot_done = (cnt == 3'h1);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] FMASK = 32'h84C2_A6E0;
	logic        core_clk, reset, branch_valid, fcmp_valid;
	logic        fpu_enable_flag, float_enable_state, fpu_present;
	logic        branch_ready, slot_done, result_valid, result_taken;
	logic        result_annul, not_branch, fp_unavailable_trap;
	logic        redirect_valid;
	logic [31:0] branch_word, r;
	logic [63:0] branch_pc, result_target, redirect_pc;
	logic [3:0]  int_cond_codes;
	logic [1:0]  fcmp_result, fp_cond_code_zero;
	logic [2:0]  slot_wait;
	int          bad_count, n_tests, seed, mfcc;

	cbe_branch_eval #(.PC_W(64)) uut (.core_clk, .reset, .branch_valid,
		.branch_ready, .branch_word, .branch_pc, .int_cond_codes,
		.fcmp_valid, .fcmp_result, .fpu_enable_flag, .float_enable_state,
		.fpu_present, .slot_done, .result_valid, .result_taken,
		.result_annul, .result_target, .not_branch, .fp_unavailable_trap,
		.redirect_valid, .redirect_pc, .fp_cond_code_zero);
	cbe_slot_model far (.core_clk, .reset, .result_valid, .slot_wait,
		.slot_done);

	always #5 core_clk = ~core_clk;

	task automatic chk(input string nm, input logic [63:0] s, e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// one branch, checked against the model
	// ----------------------------------------
	task automatic do_br(input logic [31:0] w, input logic fw,
		input logic [1:0] fr);
		logic [63:0] pc, tg;
		logic [7:0]  iv;
		logic [3:0]  ic, c;
		int          fp, ok, en, tk, an;
		pc = {$random(seed), $random(seed)};
		ic = $random(seed);
		c = w[28:25];
		for (int i = 0; i < 20 && branch_ready !== 1'b1; i++)
			@(negedge core_clk);
		branch_valid = 1;
		branch_word = w;
		branch_pc = pc;
		int_cond_codes = ic;
		fcmp_valid = fw;
		fcmp_result = fr;
		slot_wait = 3'h1 + 3'($random(seed) & 3);
		if (fw)
			mfcc = fr;
		iv = {ic[1], ic[3], ic[0], ic[0] | ic[2], ic[3] ^ ic[1],
			ic[2] | (ic[3] ^ ic[1]), ic[2], 1'b0};
		fp = (w[24:22] == 3'h6);
		ok = (w[31:30] == 2'h0) && (fp || w[24:22] == 3'h2);
		en = fpu_enable_flag && float_enable_state && fpu_present;
		tk = c[3] ^ (fp ? FMASK[4 * c[2:0] + mfcc] : iv[c[2:0]]);
		an = (c[2:0] == 3'h0) ? w[29] : (w[29] && !tk);
		tg = pc + {{40{w[21]}}, w[21:0], 2'h0};
		@(negedge core_clk);
		branch_valid = 0;
		fcmp_valid = 0;
		chk("trap", fp_unavailable_trap, ok && fp && !en);
		chk("nobr", not_branch, !ok);
		chk("done", result_valid, ok && (!fp || en));
		chk("fcc", fp_cond_code_zero, mfcc);
		if (ok && (!fp || en)) begin
			chk("taken", result_taken, tk);
			chk("annul", result_annul, an);
			chk("target", result_target, tg);
			for (int i = 0; i < 20 && branch_ready !== 1'b1; i++)
				@(negedge core_clk);
			chk("redir", redirect_valid, tk);
			if (tk)
				chk("rpc", redirect_pc, tg);
		end
	endtask

	initial begin
		#200_000;
		bad_count++;
		print_verdict;
	end

	initial begin
		{core_clk, reset, branch_valid, fcmp_valid} = 4'h4;
		{branch_word, branch_pc, int_cond_codes, fcmp_result} = '0;
		{fpu_enable_flag, float_enable_state, fpu_present} = 3'h7;
		slot_wait = 3'h1;
		{seed, mfcc, bad_count, n_tests} = {32'h6A43, 96'h0};
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		reset = 0;
		for (int c = 0; c < 64; c++) begin
			r = $random(seed);
			do_br({2'h0, r[0], 4'(c), 3'h2, r[22:1]}, r[23], r[25:24]);
		end
		$display("test integer done");
		// odd conditions load the code first; a stray load must not stick
		for (int c = 0; c < 64; c++) begin
			r = $random(seed);
			if (c[0]) begin
				fcmp_valid = 1;
				fcmp_result = 2'(c >> 4);
				mfcc = c >> 4;
				@(negedge core_clk);
				fcmp_valid = 0;
			end
			do_br({2'h0, r[0], 4'(c), 3'h6, r[22:1]}, !c[0],
				2'(c >> 4) ^ {2{c[0]}});
		end
		$display("test float done");
		for (int k = 0; k < 3; k++) begin
			{fpu_enable_flag, float_enable_state, fpu_present} = ~(3'h1 << k);
			do_br({2'h0, 1'b1, 4'h8, 3'h6, 22'h3FFFFF}, 1'b0, 2'h0);
		end
		{fpu_enable_flag, float_enable_state, fpu_present} = 3'h7;
		do_br(32'h4000_0000, 1'b0, 2'h0);
		do_br({2'h0, 1'b0, 4'h8, 3'h0, 22'h0}, 1'b0, 2'h0);
		do_br({2'h0, 1'b1, 4'h8, 3'h2, 22'h200000}, 1'b0, 2'h0);
		$display("test trap and decode done");
		print_verdict;
	end
endmodule
`default_nettype wire
